// ---- core/dcf_core.sv ----
// Command front end of a four-bank 32-bit DDR memory: pin sampling, decode,
// mode registers, DLL lock tracking, burst ordering and write data capture.
// Assumes clk oversamples the memory clock, strobes and all pins (2-flop sync).

module dcf_core
    import dcf_pkg::*;
#(
    parameter int DLL_WAIT = DLL_LOCK_CYCLES  // Lock wait in memory clocks
) (
    // System
    input  wire logic                 clk,
    input  wire logic                 resetn,
    // Memory command pins
    input  wire logic                 mem_clk,
    input  wire logic                 clock_enable,
    input  wire logic                 chip_select_n,
    input  wire logic                 row_strobe_n,
    input  wire logic                 column_strobe_n,
    input  wire logic                 write_enable_n,
    input  wire logic [ADDR_W-1:0]    address_pins,
    input  wire logic [BANK_W-1:0]    bank_select,
    // Write data lanes
    input  wire logic [LANES-1:0]     data_strobe,
    input  wire logic [LANES-1:0]     data_mask,
    input  wire logic [8*LANES-1:0]   data_in,
    // Decoded command
    output logic [2:0]                cmd_code,
    output logic                      cmd_valid,
    output logic [ADDR_W-1:0]         row_addr,
    output logic [COL_W-1:0]          col_addr,
    output logic                      auto_close_row,
    output logic [BANK_W-1:0]         cmd_bank,
    // Mode state
    output logic [2:0]                burst_len_code,
    output logic                      burst_interleave,
    output logic [2:0]                read_latency,
    output logic                      test_mode,
    output logic                      dll_enabled,
    output logic [1:0]                drive_strength,
    output logic                      dll_locked,
    output logic                      powered_up,
    output logic                      mode_illegal,
    // Burst ordering
    output logic [COL_W-1:0]          burst_col,
    // Captured write data
    output logic [8*LANES-1:0]        wr_data,
    output logic [LANES-1:0]          wr_byte_en,
    output logic                      wr_valid
);
    // Lock timer is eight bits wide: refuse waits it cannot hold
    if (DLL_WAIT < 1 || DLL_WAIT > 255) begin
        $error("DLL_WAIT out of range");
    end

    // Reset synchroniser
    // Release is clocked so every flop leaves reset on the same edge
    logic rst_m, rst_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_m <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_q <= rst_m;
        end
    end

    // Two-flop synchronisers for every pin
    // Costs two cycles on every pin, so clk must run over four times mem_clk
    localparam int PW = 6 + ADDR_W + BANK_W + 2*LANES + 8*LANES;
    logic [PW-1:0] pin_m, pin_s;
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            pin_m <= '0;
            pin_s <= '0;
        end else begin
            pin_m <= {mem_clk, clock_enable, chip_select_n, row_strobe_n,
                      column_strobe_n, write_enable_n, address_pins, bank_select,
                      data_strobe, data_mask, data_in};
            pin_s <= pin_m;
        end
    end

    // Unpacked view of synchronised pins
    // Short local names keep the decode below readable
    logic                s_ck, s_cke, s_cs_n, s_ras_n, s_cas_n, s_we_n;
    logic [ADDR_W-1:0]   s_addr;
    logic [BANK_W-1:0]   s_ba;
    logic [LANES-1:0]    s_dqs, s_dm;
    logic [8*LANES-1:0]  s_dq;
    assign {s_ck, s_cke, s_cs_n, s_ras_n, s_cas_n, s_we_n, s_addr, s_ba,
            s_dqs, s_dm, s_dq} = pin_s;

    // Burst order: offset within wrap window of given size
    // Full page wraps over the whole row and never interleaves
    function automatic logic [COL_W-1:0] burst_next(input logic [COL_W-1:0] start,
                                                    input logic [COL_W-1:0] beat,
                                                    input logic [2:0] blc,
                                                    input logic inter);
        logic [COL_W-1:0] wmask;
        wmask = 8'h00;
        unique case (blc)
            BL_2:    wmask = 8'h01;
            BL_4:    wmask = 8'h03;
            BL_8:    wmask = 8'h07;
            default: wmask = 8'hFF;
        endcase
        if (inter && blc != BL_FULL)
            burst_next = (start & ~wmask) | ((start ^ beat) & wmask);
        else
            burst_next = (start & ~wmask) | ((start + beat) & wmask);
    endfunction

    // All state in one struct
    // Edge detectors, mode copies, lock timer, command fields, burst walk
    typedef struct packed {
        logic                ck_prev;
        logic [LANES-1:0]    dqs_prev;
        logic [ADDR_W-1:0]   mr;
        logic [ADDR_W-1:0]   emr;
        logic                mr_written;
        logic                emr_written;
        logic [7:0]          lock_cnt;
        logic                locked;
        logic [2:0]          cmd;
        logic                valid;
        logic [ADDR_W-1:0]   row;
        logic [COL_W-1:0]    col;
        logic                ap;
        logic [BANK_W-1:0]   bank;
        logic [COL_W-1:0]    start;
        logic [COL_W-1:0]    beat;
        logic                in_burst;
        logic [COL_W-1:0]    bcol;
        logic [8*LANES-1:0]  wdata;
        logic [LANES-1:0]    wen;
        logic                wvld;
    } dcf_state_s;

    dcf_state_s st, next_st;

    // One-cycle enable on each rise of the sampled memory clock
    logic ck_rise;
    assign ck_rise = s_ck && !st.ck_prev;

    // Next state
    always_comb begin
        next_st          = st;
        next_st.ck_prev  = s_ck;
        next_st.dqs_prev = s_dqs;
        next_st.valid    = 1'b0;
        next_st.wvld     = 1'b0;
        next_st.wen      = '0;
        // Pulses fall back low; held fields keep their value
        // Clock enable gating
        if (ck_rise && s_cke) begin
            // DLL lock counter runs on memory clocks
            if (st.lock_cnt != 8'h00) begin
                next_st.lock_cnt = st.lock_cnt - 8'h01;
                if (st.lock_cnt == 8'h01)
                    next_st.locked = 1'b1;
            end
            // Burst column walk
            // Walk never stops by itself; a new column command restarts it
            if (st.in_burst) begin
                next_st.beat = st.beat + 8'h01;
                next_st.bcol = burst_next(st.start, st.beat + 8'h01,
                                          st.mr[MR_BL_LSB +: 3], st.mr[MR_BT_BIT]);
            end
            if (!s_cs_n) begin
                next_st.cmd   = {s_ras_n, s_cas_n, s_we_n};
                next_st.valid = ({s_ras_n, s_cas_n, s_we_n} != CMD_NOP);
                next_st.bank  = s_ba;
                if ({s_ras_n, s_cas_n, s_we_n} == CMD_ACT)
                    next_st.row = s_addr;
                if ({s_ras_n, s_cas_n, s_we_n} == CMD_READ ||
                    {s_ras_n, s_cas_n, s_we_n} == CMD_WRITE) begin
                    next_st.col      = s_addr[COL_W-1:0];
                    next_st.ap       = s_addr[AUTO_CLOSE_BIT];
                    next_st.start    = (st.mr[MR_BL_LSB +: 3] == BL_FULL) ?
                                       {s_addr[COL_W-1:1], 1'b0} : s_addr[COL_W-1:0];
                    next_st.beat     = 8'h00;
                    next_st.bcol     = next_st.start;
                    next_st.in_burst = 1'b1;
                end
                if ({s_ras_n, s_cas_n, s_we_n} == CMD_MODE) begin
                    if (s_ba[0]) begin
                        next_st.emr         = s_addr;
                        next_st.emr_written = 1'b1;
                        if (!s_addr[EMR_DLL_BIT]) begin
                            next_st.lock_cnt = 8'(DLL_WAIT);
                            next_st.locked   = 1'b0;
                        end
                    end else begin
                        next_st.mr         = s_addr;
                        next_st.mr_written = 1'b1;
                        // DLL reset bit restarts the lock timer
                        if (s_addr[MR_DLLR_BIT]) begin
                            next_st.lock_cnt = 8'(DLL_WAIT);
                            next_st.locked   = 1'b0;
                        end
                    end
                end
            end
        end
        // Per-lane strobe capture on both edges
        for (int i = 0; i < LANES; i++) begin
            // Either edge of the lane strobe takes its byte
            if (s_cke && (s_dqs[i] != st.dqs_prev[i])) begin
                next_st.wvld = 1'b1;
                if (!s_dm[i]) begin
                    next_st.wen[i] = 1'b1;
                    next_st.wdata[8*i +: 8] = s_dq[8*i +: 8];
                end
            end
        end
    end

    // State register; mode contents persist until rewritten
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            // Real contents are undefined; zero is a safe start
            st      <= '0;
            st.mr   <= MR_RESET;
            st.emr  <= EMR_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign burst_len_code   = st.mr[MR_BL_LSB +: 3];
    assign burst_interleave = st.mr[MR_BT_BIT];
    assign read_latency     = st.mr[MR_RL_LSB +: 3];
    assign test_mode        = st.mr[MR_TM_BIT];
    // DLL enable is active low bit, drive strength pair
    assign dll_enabled      = st.emr_written && !st.emr[EMR_DLL_BIT];
    assign drive_strength   = {st.emr[EMR_DRV1_BIT], st.emr[EMR_DRV0_BIT]};
    assign dll_locked       = st.locked;
    assign powered_up       = st.mr_written && st.emr_written;
    // Only latency 3/4, legal lengths, full page sequential
    assign mode_illegal = st.mr_written &&
        (!(read_latency == RL_3 || read_latency == RL_4) ||
         !(burst_len_code inside {BL_2, BL_4, BL_8, BL_FULL}) ||
         (burst_len_code == BL_FULL && burst_interleave));

    // Registered command fields hold until the next selected command
    assign cmd_code       = st.cmd;
    assign cmd_valid      = st.valid;
    assign row_addr       = st.row;
    assign col_addr       = st.col;
    assign auto_close_row = st.ap;
    assign cmd_bank       = st.bank;
    assign burst_col      = st.bcol;
    assign wr_data        = st.wdata;
    assign wr_byte_en     = st.wen;
    assign wr_valid       = st.wvld;

    // Assertions
    // They watch the sampled pins, which is what the decoder really sees
    ignore_deselect_a: assert property (@(posedge clk) disable iff (!rst_q)
        (ck_rise && s_cs_n) |=> !cmd_valid)
        else $error("command taken while deselected");
    cke_gate_a: assert property (@(posedge clk) disable iff (!rst_q)
        (!s_cke) |=> (!cmd_valid && wr_byte_en == '0))
        else $error("activity with clock enable low");
    mode_capture_a: assert property (@(posedge clk) disable iff (!rst_q)
        (ck_rise && s_cke && !s_cs_n && {s_ras_n, s_cas_n, s_we_n} == CMD_MODE && !s_ba[0])
        |=> (st.mr == $past(s_addr)))
        else $error("mode register not captured");
    ext_capture_a: assert property (@(posedge clk) disable iff (!rst_q)
        (ck_rise && s_cke && !s_cs_n && {s_ras_n, s_cas_n, s_we_n} == CMD_MODE && s_ba[0])
        |=> (st.emr == $past(s_addr) && $stable(st.mr)))
        else $error("extended register not captured");
    mask_block_a: assert property (@(posedge clk) disable iff (!rst_q)
        (s_cke && s_dm[0] && s_dqs[0] != st.dqs_prev[0]) |=> !wr_byte_en[0])
        else $error("masked byte written");
    col_split_a: assert property (@(posedge clk) disable iff (!rst_q)
        (ck_rise && s_cke && !s_cs_n && {s_ras_n, s_cas_n, s_we_n} == CMD_WRITE)
        |=> (col_addr == $past(s_addr[7:0]) && auto_close_row == $past(s_addr[8])))
        else $error("column split wrong");
    mode_hold_a: assert property (@(posedge clk) disable iff (!rst_q)
        !(ck_rise && s_cke && !s_cs_n && {s_ras_n, s_cas_n, s_we_n} == CMD_MODE)
        |=> $stable(st.mr) && $stable(st.emr))
        else $error("mode register changed without write");
    dll_relock_a: assert property (@(posedge clk) disable iff (!rst_q)
        (ck_rise && s_cke && !s_cs_n && {s_ras_n, s_cas_n, s_we_n} == CMD_MODE
         && s_ba[0] && !s_addr[0]) |=> (!dll_locked && st.lock_cnt == 8'(DLL_WAIT)))
        else $error("DLL lock not restarted");
    burst_start_a: assert property (@(posedge clk) disable iff (!rst_q)
        (ck_rise && s_cke && !s_cs_n && {s_ras_n, s_cas_n, s_we_n} == CMD_READ
         && burst_len_code != BL_FULL) |=> (burst_col == col_addr))
        else $error("burst does not start at column");
    // First step after a column command in a sequential burst of four
    burst_walk_a: assert property (@(posedge clk) disable iff (!rst_q)
        (ck_rise && s_cke && s_cs_n && st.in_burst && st.beat == 8'h00
         && burst_len_code == BL_4 && !burst_interleave)
        |=> (burst_col[1:0] == $past(burst_col[1:0]) + 2'h1
             && burst_col[7:2] == $past(burst_col[7:2])))
        else $error("sequential burst step wrong");
    // Byte one lands from data bits 15:8 when its mask is low
    lane_pair_a: assert property (@(posedge clk) disable iff (!rst_q)
        (s_cke && !s_dm[1] && s_dqs[1] != st.dqs_prev[1])
        |=> (wr_byte_en[1] && wr_data[15:8] == $past(s_dq[15:8])))
        else $error("byte lane one not captured");
    c_mode_w: cover property (@(posedge clk) disable iff (!rst_q) $rose(powered_up));
    c_lock:   cover property (@(posedge clk) disable iff (!rst_q) $rose(dll_locked));
    c_write:  cover property (@(posedge clk) disable iff (!rst_q) wr_valid && wr_byte_en == 4'hF);
    // Scenarios worth seeing in a run
    c_read:   cover property (@(posedge clk) disable iff (!rst_q)
        cmd_valid && cmd_code == CMD_READ);
    c_mask:   cover property (@(posedge clk) disable iff (!rst_q)
        wr_valid && wr_byte_en != 4'hF && wr_byte_en != 4'h0);
endmodule

// ---- core/dcf_pkg.sv ----
// Constants for the DDR command front end: opcodes, field positions and timing.
// Assumes a single 40 MHz system clock that samples all memory pins.
package dcf_pkg;
    // Widths of the command side
    localparam int ADDR_W    = 12;
    localparam int BANK_W    = 2;
    localparam int LANES     = 4;
    localparam int COL_W     = 8;
    // Command codes {ras_n, cas_n, we_n}
    localparam logic [2:0] CMD_NOP     = 3'h7;
    localparam logic [2:0] CMD_ACT     = 3'h3;
    localparam logic [2:0] CMD_READ    = 3'h5;
    localparam logic [2:0] CMD_WRITE   = 3'h4;
    localparam logic [2:0] CMD_PRE     = 3'h2;
    localparam logic [2:0] CMD_REF     = 3'h1;
    localparam logic [2:0] CMD_MODE    = 3'h0;
    // Mode register fields
    localparam int MR_BL_LSB   = 0;
    localparam int MR_BT_BIT   = 3;
    localparam int MR_RL_LSB   = 4;
    localparam int MR_TM_BIT   = 7;
    localparam int MR_DLLR_BIT = 8;
    localparam int AUTO_CLOSE_BIT = 8;
    // Extended mode register fields
    localparam int EMR_DLL_BIT  = 0;
    localparam int EMR_DRV0_BIT = 1;
    localparam int EMR_DRV1_BIT = 6;
    // Burst length codes
    localparam logic [2:0] BL_2    = 3'h1;
    localparam logic [2:0] BL_4    = 3'h2;
    localparam logic [2:0] BL_8    = 3'h3;
    localparam logic [2:0] BL_FULL = 3'h7;
    // Read latency codes
    localparam logic [2:0] RL_3 = 3'h3;
    localparam logic [2:0] RL_4 = 3'h4;
    // Reset values of the stored registers (contents undefined, zero chosen)
    localparam logic [ADDR_W-1:0] MR_RESET  = 12'h000;
    localparam logic [ADDR_W-1:0] EMR_RESET = 12'h000;
    // DLL lock wait in memory clock cycles
    localparam int DLL_LOCK_CYCLES = 200;
    localparam logic [7:0] DLL_LOCK_CNT = 8'(DLL_LOCK_CYCLES);
endpackage

// ---- test/dcf_ctrl_model.sv ----
// Controller model: free-running memory clock, command pins, data lanes.
// Assumes dcf_pkg and a system clock eight times the memory clock.
module dcf_ctrl_model
    import dcf_pkg::*;
(
    // System
    input  wire logic          clk,
    // Command pins
    output logic               mem_clk,
    output logic               clock_enable,
    output logic               chip_select_n,
    output logic               row_strobe_n,
    output logic               column_strobe_n,
    output logic               write_enable_n,
    output logic [ADDR_W-1:0]  address_pins,
    output logic [BANK_W-1:0]  bank_select,
    // Data lanes
    output logic [LANES-1:0]   data_strobe,
    output logic [LANES-1:0]   data_mask,
    output logic [8*LANES-1:0] data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] phase = 3'h0;  // Position in one memory clock period

    // Quiet pins at time zero, clock enable low for power-up
    initial begin
        clock_enable = 1'b0;
        chip_select_n = 1'b1;
        {row_strobe_n, column_strobe_n, write_enable_n} = CMD_NOP;
        address_pins = 12'h000;
        bank_select = 2'h0;
        data_strobe = 4'h0;
        data_mask = 4'h0;
        data_in = 32'h0;
    end

    // Memory clock runs free: real controllers never stop it
    always @(posedge clk) begin
        phase <= phase + 3'h1;
    end
    assign mem_clk = phase[2];

    // Wait for the start of the low half; the phase wraps within eight cycles
    task automatic align;
        for (int n = 0; n < 8; n++) begin
            @(posedge clk);
            if (phase == 3'h7) break;
        end
    endtask

    // clock enable changes only with the clock low
    task automatic set_cke(input logic cke);
        align();
        clock_enable <= cke;
    endtask

    // pins stable around one rising memory clock edge
    task automatic issue(input logic cs_n, input logic [2:0] cmd,
                         input logic [BANK_W-1:0] ba, input logic [ADDR_W-1:0] addr);
        align();
        chip_select_n <= cs_n;
        {row_strobe_n, column_strobe_n, write_enable_n} <= cmd;
        bank_select <= ba;
        address_pins <= addr;
        repeat (8) @(posedge clk);
        // Released bus goes deselected with a NOP; bank and address show the inverse, never a stale value
        chip_select_n <= 1'b1;
        {row_strobe_n, column_strobe_n, write_enable_n} <= CMD_NOP;
        bank_select <= ~ba;
        address_pins <= ~addr;
        // half a memory clock before the next command
        repeat (4) @(posedge clk);
    endtask

    // data and mask centred on one edge of all four strobes
    task automatic strobe(input logic [LANES-1:0] dm, input logic [8*LANES-1:0] dat);
        @(posedge clk);
        data_mask <= dm;
        data_in <= dat;
        repeat (4) @(posedge clk);
        data_strobe <= ~data_strobe;
        repeat (4) @(posedge clk);
        data_mask <= ~dm;
        data_in <= ~dat;
        repeat (4) @(posedge clk);
    endtask
endmodule

// ---- test/ddr_sdram_command_init_tb_top.sv ----
// Testbench: power-up sequence, decode, mode table and write lanes.
// Assumes dcf_core with a short DLL lock count and the controller model.
module ddr_sdram_command_init_tb_top;
    import dcf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LOCK = 4;  // Shortened DLL lock count
    // Mode table: length, type, latency, expected illegal flag
    localparam logic [2:0] BLS [7] = '{BL_8, BL_2, BL_FULL, BL_FULL, BL_4, BL_2, 3'h0};
    localparam logic [2:0] RLS [7] = '{RL_4, RL_3, RL_3, RL_3, 3'h2, RL_4, RL_3};
    localparam logic       BTS [7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    localparam logic       ILS [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    // Burst columns from start five, length four: sequential then interleaved
    localparam logic [7:0] BCOL [8] = '{8'h05, 8'h06, 8'h07, 8'h04,
                                        8'h05, 8'h04, 8'h07, 8'h06};
    logic              clk;
    logic              resetn;
    logic              mem_clk, cke, cs_n, ras_n, cas_n, we_n;
    logic [11:0]       addr, row_addr;
    logic [1:0]        ba, cmd_bank, drive_strength;
    logic [3:0]        dqs, dm, wr_byte_en;
    logic [31:0]       din, wr_data, last_data;
    logic [2:0]        cmd_code, burst_len_code, read_latency;
    logic [7:0]        col_addr, burst_col;
    logic              cmd_valid, auto_close_row, burst_interleave, test_mode;
    logic              dll_enabled, dll_locked, powered_up, mode_illegal, wr_valid;
    int                num_errors, checks, ncmd, nwr;

    dcf_ctrl_model i_ctrl (.clk(clk), .mem_clk(mem_clk), .clock_enable(cke),
        .chip_select_n(cs_n), .row_strobe_n(ras_n), .column_strobe_n(cas_n),
        .write_enable_n(we_n), .address_pins(addr), .bank_select(ba),
        .data_strobe(dqs), .data_mask(dm), .data_in(din));

    dcf_core #(.DLL_WAIT(LOCK)) i_dut (.clk(clk), .resetn(resetn), .mem_clk(mem_clk),
        .clock_enable(cke), .chip_select_n(cs_n), .row_strobe_n(ras_n),
        .column_strobe_n(cas_n), .write_enable_n(we_n), .address_pins(addr),
        .bank_select(ba), .data_strobe(dqs), .data_mask(dm), .data_in(din),
        .cmd_code(cmd_code), .cmd_valid(cmd_valid), .row_addr(row_addr),
        .col_addr(col_addr), .auto_close_row(auto_close_row), .cmd_bank(cmd_bank),
        .burst_len_code(burst_len_code), .burst_interleave(burst_interleave),
        .read_latency(read_latency), .test_mode(test_mode), .dll_enabled(dll_enabled),
        .drive_strength(drive_strength), .dll_locked(dll_locked),
        .powered_up(powered_up), .mode_illegal(mode_illegal), .burst_col(burst_col),
        .wr_data(wr_data), .wr_byte_en(wr_byte_en), .wr_valid(wr_valid));

    // 40 MHz system clock
    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    // Count one-cycle pulses so no window can miss them
    always @(posedge clk) begin
        if (cmd_valid === 1'b1) ncmd++;
        if (wr_valid === 1'b1) begin
            nwr++;
            last_data = wr_data & {{8{wr_byte_en[3]}}, {8{wr_byte_en[2]}},
                                   {8{wr_byte_en[1]}}, {8{wr_byte_en[0]}}};
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test;
        if (num_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Power-up steps, DLL lock wait and final mode write
    task automatic t_init;
        int n;
        chk("reset powered_up", 0, powered_up);
        i_ctrl.set_cke(1'b1);
        i_ctrl.issue(1'b0, CMD_NOP, 2'h0, 12'h000);
        i_ctrl.issue(1'b0, CMD_PRE, 2'h0, 12'h400);
        i_ctrl.issue(1'b0, CMD_MODE, 2'h1, 12'h042);
        chk("dll_enabled", 1, dll_enabled);
        chk("drive_strength", 2'h3, drive_strength);
        chk("early powered_up", 0, powered_up);
        repeat (8) @(posedge clk);
        chk("early lock", 0, dll_locked);
        n = 0;
        while (dll_locked !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        chk("dll_locked", 1, dll_locked);
        i_ctrl.issue(1'b0, CMD_MODE, 2'h0, 12'h132);
        chk("relock", 0, dll_locked);
        i_ctrl.issue(1'b0, CMD_PRE, 2'h0, 12'h400);
        i_ctrl.issue(1'b0, CMD_REF, 2'h0, 12'h000);
        i_ctrl.issue(1'b0, CMD_REF, 2'h0, 12'h000);
        i_ctrl.issue(1'b0, CMD_MODE, 2'h0, 12'h032);
        chk("burst_len_code", BL_4, burst_len_code);
        chk("burst_interleave", 0, burst_interleave);
        chk("read_latency", RL_3, read_latency);
        chk("test_mode", 0, test_mode);
        chk("powered_up", 1, powered_up);
        chk("dll after init", 1, dll_locked);
    endtask

    // Decode, fields, deselect and clock enable low
    task automatic t_cmd;
        int n0;
        n0 = ncmd;
        i_ctrl.issue(1'b0, CMD_ACT, 2'h2, 12'hABC);
        chk("act code", CMD_ACT, cmd_code);
        chk("row_addr", 12'hABC, row_addr);
        chk("act bank", 2'h2, cmd_bank);
        i_ctrl.issue(1'b0, CMD_WRITE, 2'h1, 12'h1A5);
        chk("col_addr", 8'hA5, col_addr);
        chk("auto_close_row", 1, auto_close_row);
        chk("cmd count", 2, ncmd - n0);
        i_ctrl.issue(1'b1, CMD_READ, 2'h3, 12'h0FF);
        chk("deselected code", CMD_WRITE, cmd_code);
        i_ctrl.set_cke(1'b0);
        i_ctrl.issue(1'b0, CMD_READ, 2'h3, 12'h0FF);
        i_ctrl.set_cke(1'b1);
        chk("ignored count", 2, ncmd - n0);
        chk("kept latency", RL_3, read_latency);
    endtask

    // Seven length, type and latency combinations, legal and not
    task automatic t_modes;
        i_ctrl.issue(1'b0, CMD_PRE, 2'h0, 12'h400);
        for (int i = 0; i < 7; i++) begin
            i_ctrl.issue(1'b0, CMD_MODE, 2'h0, {5'h00, RLS[i], BTS[i], BLS[i]});
            chk("mode length", BLS[i], burst_len_code);
            chk("mode type", BTS[i], burst_interleave);
            chk("mode latency", RLS[i], read_latency);
            chk("mode_illegal", ILS[i], mode_illegal);
        end
        chk("emr kept", 2'h3, drive_strength);
    endtask

    // Burst ordering from column five, sequential then interleaved
    task automatic t_burst;
        for (int m = 0; m < 2; m++) begin
            i_ctrl.issue(1'b0, CMD_PRE, 2'h0, 12'h400);
            i_ctrl.issue(1'b0, CMD_MODE, 2'h0, {5'h00, RL_3, m[0], BL_4});
            i_ctrl.issue(1'b0, CMD_ACT, 2'h1, 12'h010);
            i_ctrl.issue(1'b0, CMD_READ, 2'h1, 12'h005);
            for (int b = 0; b < 4; b++) begin
                chk("burst_col", BCOL[4*m+b], burst_col);
                repeat (8) @(posedge clk);
            end
        end
    endtask

    // Byte lanes, masks, and strobes ignored with clock enable low
    task automatic t_data;
        int n0;
        n0 = nwr;
        i_ctrl.strobe(4'h5, 32'h44332211);
        chk("masked data", 32'h44002200, last_data);
        i_ctrl.strobe(4'h0, 32'hDEADBEEF);
        chk("falling edge data", 32'hDEADBEEF, last_data);
        i_ctrl.strobe(4'h8, 32'h12345678);
        chk("top lane masked", 32'h00345678, last_data);
        chk("wr count", 3, nwr - n0);
        i_ctrl.set_cke(1'b0);
        i_ctrl.strobe(4'h0, 32'hA5A5A5A5);
        i_ctrl.set_cke(1'b1);
        chk("strobe ignored", 3, nwr - n0);
    endtask

    // Hang guard
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        $display("MISMATCH watchdog expected %h seen %h", 0, 1);
        finish_test();
    end

    // Main sequence: reset for 16 cycles, then the scenarios
    initial begin
        resetn = 1'b0;
        num_errors = 0;
        checks = 0;
        ncmd = 0;
        nwr = 0;
        last_data = 32'h0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        t_init();
        t_cmd();
        t_modes();
        t_burst();
        t_data();
        finish_test();
    end
endmodule
